/* csmf_defs.vh */
// Purpose: constants for the CAN status and mailbox flag block
// Assumes: 32-bit AXI4-Lite register bus, word aligned
// Notes: offsets are byte addresses
`ifndef CSMF_DEFS_VH
`define CSMF_DEFS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CSMF_OFS_GLOBAL_STATUS   6'h00
`define CSMF_OFS_CTRL            6'h04
`define CSMF_OFS_TX_DONE_LOWER   6'h08
`define CSMF_OFS_TX_DONE_UPPER   6'h0c
`define CSMF_OFS_REMOTE_PENDING  6'h10
`define CSMF_OFS_OVERWRITE       6'h14
`define CSMF_OFS_RX_COMPLETE     6'h18
`define CSMF_OFS_MBOX_IRQ_MASK   6'h1c
`define CSMF_OFS_IRQ_MASK        6'h20
`define CSMF_OFS_IRQ_STATUS      6'h24
`define CSMF_OFS_CANCEL_REQ      6'h28
`define CSMF_OFS_TX_PENDING      6'h2c

// ----------------------------------------
// global status fields
// ----------------------------------------
`define CSMF_GS_HALT_SLEEP   4
`define CSMF_GS_RESET_STATE  3
`define CSMF_GS_TX_IDLE      2
`define CSMF_GS_WARNING      1

// ----------------------------------------
// control fields
// ----------------------------------------
`define CSMF_CTRL_CONFIG  0
`define CSMF_CTRL_HALT    1
`define CSMF_CTRL_SLEEP   5

// ----------------------------------------
// irq mask register fields (1 = masked)
// ----------------------------------------
`define CSMF_IM_REMOTE      2
`define CSMF_IM_MBOX_EMPTY  8
`define CSMF_IM_OVERWRITE   9

// ----------------------------------------
// irq status fields
// ----------------------------------------
`define CSMF_IS_CANCEL     0
`define CSMF_IS_REMOTE     1
`define CSMF_IS_OVERWRITE  2

// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define CSMF_CTRL_RESET      16'h0001
`define CSMF_MBOX_MASK_RESET 32'hffffffff
`define CSMF_IM_RESET        16'hffff
`define CSMF_WARN_LIMIT      9'd96
`define CSMF_NORMAL_DELAY    4'd4

`endif

/* csmf_warn.v */
// Purpose: error counter warning evaluation
// Assumes: counters are 9 bits, 256 and up means bus off
// Notes: purely combinational
`timescale 1ns/1ps
`include "csmf_defs.vh"

module csmf_warn (
	// counters
	input  wire [8:0] TX_ERR_CNT,
	input  wire [8:0] RX_ERR_CNT,
	// result
	output wire       WARN
);

	wire tx_hi;
	wire tx_off;
	wire rx_hi;

	assign tx_off = TX_ERR_CNT[8];
	assign tx_hi  = (TX_ERR_CNT >= `CSMF_WARN_LIMIT) && !tx_off;
	assign rx_hi  = (RX_ERR_CNT >= `CSMF_WARN_LIMIT) && !RX_ERR_CNT[8];
	// bus off of the transmitter overrides a high receive count
	assign WARN   = (tx_hi || rx_hi) && !tx_off;

endmodule // csmf_warn

/* csmf_flags.v */
// Purpose: CAN status and mailbox event flags behind an AXI4-Lite slave
// Assumes: protocol engine drives event pulses on CLK_SYS; counters synchronous
// Notes: masks use 1 = masked, 0 = enabled
`timescale 1ns/1ps
`include "csmf_defs.vh"

module csmf_flags #(
	parameter NMB = 32
) (
	// clock and reset
	input  wire           CLK_SYS,
	input  wire           RST,
	// axi4-lite write address
	input  wire [5:0]     S_AXI_AWADDR,
	input  wire           S_AXI_AWVALID,
	output wire           S_AXI_AWREADY,
	// axi4-lite write data
	input  wire [31:0]    S_AXI_WDATA,
	input  wire [3:0]     S_AXI_WSTRB,
	input  wire           S_AXI_WVALID,
	output wire           S_AXI_WREADY,
	// axi4-lite write response
	output reg  [1:0]     S_AXI_BRESP,
	output reg            S_AXI_BVALID,
	input  wire           S_AXI_BREADY,
	// axi4-lite read address
	input  wire [5:0]     S_AXI_ARADDR,
	input  wire           S_AXI_ARVALID,
	output wire           S_AXI_ARREADY,
	// axi4-lite read data
	output reg  [31:0]    S_AXI_RDATA,
	output reg  [1:0]     S_AXI_RRESP,
	output reg            S_AXI_RVALID,
	input  wire           S_AXI_RREADY,
	// protocol engine state
	input  wire           BUS_IDLE,
	input  wire           INT_RESET_DONE,
	input  wire           TX_ACTIVE,
	input  wire [8:0]     TX_ERR_CNT,
	input  wire [8:0]     RX_ERR_CNT,
	input  wire [NMB-1:0] MB_ARBITRATING,
	input  wire [NMB-1:0] MB_SENDING,
	// protocol engine events
	input  wire [NMB-1:0] TX_OK,
	input  wire [NMB-1:0] RX_STORE,
	input  wire           RX_REMOTE,
	input  wire [3:0]     RX_DLC,
	// to protocol engine
	output wire [NMB-1:0] TX_PENDING,
	output wire           NORMAL_MODE,
	output wire           HALT_REQ,
	output wire           SLEEP_REQ,
	// interrupt
	output wire           IRQ
);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg [15:0]    ctrl;
	reg [NMB-1:0] tx_done;
	reg [NMB-1:0] tx_pend;
	reg [NMB-1:0] remote_pend;
	reg [NMB-1:0] overwrite;
	reg [NMB-1:0] rx_complete;
	reg [NMB-1:0] mbox_mask;
	reg [15:0]    im;
	reg [2:0]     irq_stat;
	reg [3:0]     last_dlc;
	reg           reset_state;
	reg           halt_sleep;
	reg [1:0]     mode;
	reg [3:0]     delay_cnt;

	localparam M_RESET  = 2'd0;
	localparam M_CONFIG = 2'd1;
	localparam M_DELAY  = 2'd2;
	localparam M_NORMAL = 2'd3;

	// ----------------------------------------
	// axi4-lite write channel
	// ----------------------------------------
	reg        aw_held;
	reg        w_held;
	reg [5:0]  aw_addr;
	reg [31:0] w_data;
	reg [3:0]  w_strb;
	wire       wr_fire;
	wire [6:0] wr_tag;

	assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
	assign S_AXI_WREADY  = !w_held && !S_AXI_BVALID;
	assign wr_fire       = aw_held && w_held && !S_AXI_BVALID;
	// handed to hit() as an argument so continuous assigns wake on it
	assign wr_tag        = {wr_fire, aw_addr};

	always @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= 6'h00;
			w_data       <= 32'h00000000;
			w_strb       <= 4'h0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= 2'b00;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_held <= 1'b1;
				aw_addr <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_held <= 1'b1;
				w_data <= S_AXI_WDATA;
				w_strb <= S_AXI_WSTRB;
			end
			if (wr_fire) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP  <= wr_known(aw_addr) ? 2'b00 : 2'b10;
			end else if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	function wr_known;
		input [5:0] a;
		begin
			wr_known = (a == `CSMF_OFS_CTRL) || (a == `CSMF_OFS_TX_DONE_LOWER) ||
				(a == `CSMF_OFS_TX_DONE_UPPER) || (a == `CSMF_OFS_REMOTE_PENDING) ||
				(a == `CSMF_OFS_OVERWRITE) || (a == `CSMF_OFS_RX_COMPLETE) ||
				(a == `CSMF_OFS_MBOX_IRQ_MASK) || (a == `CSMF_OFS_IRQ_MASK) ||
				(a == `CSMF_OFS_IRQ_STATUS) || (a == `CSMF_OFS_CANCEL_REQ) ||
				(a == `CSMF_OFS_TX_PENDING);
		end
	endfunction

	// byte-lane expanded write data for a given register
	function [31:0] lane;
		input [3:0]  s;
		input [31:0] d;
		begin
			lane = d & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		end
	endfunction

	function hit;
		input [6:0] t;
		input [5:0] ofs;
		begin
			hit = t[6] && (t[5:0] == ofs);
		end
	endfunction

	wire [31:0] wlane;
	wire [31:0] w1c_done;
	wire [31:0] w1c_remote;
	wire [31:0] w1c_over;
	wire [31:0] w1c_rxc;
	wire [31:0] w_cancel;
	wire [31:0] w_pend_set;

	assign wlane      = lane(w_strb, w_data);
	// two 16-bit halves of the done flags share one word each
	assign w1c_done   = (hit(wr_tag, `CSMF_OFS_TX_DONE_LOWER) ? {16'h0000, wlane[15:0]} : 32'h00000000) |
		(hit(wr_tag, `CSMF_OFS_TX_DONE_UPPER) ? {wlane[15:0], 16'h0000} : 32'h00000000);
	assign w1c_remote = hit(wr_tag, `CSMF_OFS_REMOTE_PENDING) ? wlane : 32'h00000000;
	assign w1c_over   = hit(wr_tag, `CSMF_OFS_OVERWRITE) ? wlane : 32'h00000000;
	assign w1c_rxc    = hit(wr_tag, `CSMF_OFS_RX_COMPLETE) ? wlane : 32'h00000000;
	assign w_cancel   = hit(wr_tag, `CSMF_OFS_CANCEL_REQ) ? wlane : 32'h00000000;
	assign w_pend_set = hit(wr_tag, `CSMF_OFS_TX_PENDING) ? wlane : 32'h00000000;

	// ----------------------------------------
	// mailbox flags
	// ----------------------------------------
	wire [NMB-1:0] busy;
	wire [NMB-1:0] cancel_ok;
	wire [NMB-1:0] ovw_evt;
	wire [NMB-1:0] rem_evt;

	assign busy      = MB_ARBITRATING | MB_SENDING;
	assign cancel_ok = w_cancel[NMB-1:0] & tx_pend & ~busy & ~TX_OK;
	// store happens regardless of unread contents; only flag the overwrite
	assign ovw_evt   = RX_STORE & rx_complete;
	assign rem_evt   = RX_STORE & {NMB{RX_REMOTE}};
	assign TX_PENDING = tx_pend;

	always @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			tx_done     <= {NMB{1'b0}};
			tx_pend     <= {NMB{1'b0}};
			remote_pend <= {NMB{1'b0}};
			overwrite   <= {NMB{1'b0}};
			rx_complete <= {NMB{1'b0}};
			last_dlc    <= 4'h0;
		end else begin
			// set wins over clear, except tx_pend where TX_OK and cancel win over a set write
			tx_done     <= (tx_done & ~w1c_done[NMB-1:0]) | TX_OK;
			tx_pend     <= ((tx_pend | w_pend_set[NMB-1:0]) & ~cancel_ok & ~TX_OK);
			remote_pend <= (remote_pend & ~w1c_remote[NMB-1:0]) | rem_evt;
			overwrite   <= (overwrite & ~w1c_over[NMB-1:0]) | ovw_evt;
			rx_complete <= (rx_complete & ~w1c_rxc[NMB-1:0]) | RX_STORE;
			if (|RX_STORE)
				last_dlc <= RX_DLC;
		end
	end

	// ----------------------------------------
	// interrupt events
	// ----------------------------------------
	wire ev_cancel;
	wire ev_remote;
	wire ev_over;

	assign ev_cancel = |(cancel_ok & ~mbox_mask) && !im[`CSMF_IM_MBOX_EMPTY];
	assign ev_remote = |(rem_evt & ~mbox_mask) && !im[`CSMF_IM_REMOTE];
	assign ev_over   = (|ovw_evt) && !im[`CSMF_IM_OVERWRITE];
	assign IRQ       = |irq_stat;

	always @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			irq_stat  <= 3'b000;
			ctrl      <= `CSMF_CTRL_RESET;
			im        <= `CSMF_IM_RESET;
			mbox_mask <= `CSMF_MBOX_MASK_RESET;
		end else begin
			irq_stat <= (irq_stat & ~(hit(wr_tag, `CSMF_OFS_IRQ_STATUS) ? wlane[2:0] : 3'b000)) |
				{ev_over, ev_remote, ev_cancel};
			if (hit(wr_tag, `CSMF_OFS_CTRL))
				ctrl <= wlane[15:0];
			if (hit(wr_tag, `CSMF_OFS_IRQ_MASK))
				im <= wlane[15:0];
			if (hit(wr_tag, `CSMF_OFS_MBOX_IRQ_MASK))
				mbox_mask <= wlane[NMB-1:0];
		end
	end

	// ----------------------------------------
	// operating mode and global status
	// ----------------------------------------
	wire warn;

	csmf_warn u_warn (
		.TX_ERR_CNT (TX_ERR_CNT),
		.RX_ERR_CNT (RX_ERR_CNT),
		.WARN       (warn)
	);

	assign HALT_REQ    = ctrl[`CSMF_CTRL_HALT];
	assign SLEEP_REQ   = ctrl[`CSMF_CTRL_SLEEP];
	assign NORMAL_MODE = (mode == M_NORMAL);

	always @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			mode        <= M_RESET;
			delay_cnt   <= 4'h0;
			reset_state <= 1'b1;
			halt_sleep  <= 1'b0;
		end else begin
			halt_sleep <= (HALT_REQ || SLEEP_REQ) && BUS_IDLE;
			case (mode)
				M_RESET: begin
					if (INT_RESET_DONE) begin
						mode        <= M_CONFIG;
						reset_state <= 1'b1;
					end
				end
				M_CONFIG: begin
					if (!ctrl[`CSMF_CTRL_CONFIG]) begin
						mode      <= M_DELAY;
						delay_cnt <= `CSMF_NORMAL_DELAY;
					end
				end
				M_DELAY: begin
					// lag models bus integration before joining traffic
					if (ctrl[`CSMF_CTRL_CONFIG]) begin
						mode <= M_CONFIG;
					end else if (delay_cnt == 4'h1) begin
						mode        <= M_NORMAL;
						reset_state <= 1'b0;
					end else begin
						delay_cnt <= delay_cnt - 4'h1;
					end
				end
				M_NORMAL: begin
					if (ctrl[`CSMF_CTRL_CONFIG]) begin
						mode        <= M_CONFIG;
						reset_state <= 1'b1;
					end
				end
				default: mode <= M_RESET;
			endcase
		end
	end

	wire [15:0] gstat;
	wire        tx_idle;

	assign tx_idle = !TX_ACTIVE && !(|tx_pend);
	assign gstat   = {11'h000, halt_sleep, reset_state, tx_idle, warn, 1'b0};

	// ----------------------------------------
	// axi4-lite read channel
	// ----------------------------------------
	reg [31:0] rd_mux;
	reg        rd_ok;

	assign S_AXI_ARREADY = !S_AXI_RVALID;

	always @* begin
		rd_ok  = 1'b1;
		rd_mux = 32'h00000000;
		case (S_AXI_ARADDR)
			`CSMF_OFS_GLOBAL_STATUS:  rd_mux = {16'h0000, gstat};
			`CSMF_OFS_CTRL:           rd_mux = {16'h0000, ctrl};
			`CSMF_OFS_TX_DONE_LOWER:  rd_mux = {16'h0000, tx_done[15:0]};
			`CSMF_OFS_TX_DONE_UPPER:  rd_mux = {16'h0000, tx_done[31:16]};
			`CSMF_OFS_REMOTE_PENDING: rd_mux = remote_pend;
			`CSMF_OFS_OVERWRITE:      rd_mux = overwrite;
			`CSMF_OFS_RX_COMPLETE:    rd_mux = rx_complete;
			`CSMF_OFS_MBOX_IRQ_MASK:  rd_mux = mbox_mask;
			`CSMF_OFS_IRQ_MASK:       rd_mux = {16'h0000, im};
			`CSMF_OFS_IRQ_STATUS:     rd_mux = {29'h00000000, irq_stat};
			`CSMF_OFS_CANCEL_REQ:     rd_mux = {28'h0000000, last_dlc};
			`CSMF_OFS_TX_PENDING:     rd_mux = tx_pend;
			default:                  rd_ok  = 1'b0;
		endcase
	end

	always @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA  <= 32'h00000000;
			S_AXI_RRESP  <= 2'b00;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA  <= rd_mux;
			S_AXI_RRESP  <= rd_ok ? 2'b00 : 2'b10;
		end else if (S_AXI_RVALID && S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end

endmodule // csmf_flags

/* csmf_can_node.sv */
// Purpose: far-side bus traffic model for the flag block
// Assumes: lowest pending mailbox is served first
// Notes: every frame ends without error; hold stops new frames from starting
`timescale 1ns/1ps
module csmf_can_node (
	// control
	input  wire        clk,
	input  wire        rst,
	input  wire        hold,
	// mailbox state
	input  wire [31:0] pend,
	output reg  [31:0] arb,
	output reg  [31:0] snd,
	output reg  [31:0] ok,
	output wire        idle
);
	reg [4:0] cnt;
	assign idle = ~|{arb, snd};
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			arb <= 32'h0;
			snd <= 32'h0;
			ok  <= 32'h0;
			cnt <= 5'h00;
		end else begin
			ok  <= 32'h0;
			cnt <= cnt + 5'h01;
			if (|snd && cnt == 5'h10) begin
				ok  <= snd;
				snd <= 32'h0;
			end else if (|arb) begin
				snd <= arb;
				arb <= 32'h0;
				cnt <= 5'h00;
			end else if (!hold && ~|ok && ~|snd && |pend) begin
				// skip the cycle of ok: pending is still visible then
				arb <= pend & (~pend + 32'h1);
			end
		end
	end
endmodule // csmf_can_node

/* csmf_flags_sva.sv */
// Purpose: port checks for the status and mailbox flag block
// Assumes: one clock, asynchronous active-high reset
// Notes: bound to every instance of the block
`timescale 1ns/1ps
module csmf_flags_sva #(
	parameter NMB = 32
) (
	input wire           CLK_SYS,
	input wire           RST,
	input wire           S_AXI_AWREADY,
	input wire           S_AXI_WREADY,
	input wire [1:0]     S_AXI_BRESP,
	input wire           S_AXI_BVALID,
	input wire           S_AXI_BREADY,
	input wire           S_AXI_ARVALID,
	input wire           S_AXI_ARREADY,
	input wire [31:0]    S_AXI_RDATA,
	input wire           S_AXI_RVALID,
	input wire           S_AXI_RREADY,
	input wire [NMB-1:0] MB_ARBITRATING,
	input wire [NMB-1:0] MB_SENDING,
	input wire [NMB-1:0] TX_OK,
	input wire [NMB-1:0] RX_STORE,
	input wire [NMB-1:0] TX_PENDING,
	input wire           IRQ
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	wire [NMB-1:0] busy_pend = TX_PENDING & (MB_ARBITRATING | MB_SENDING) & ~TX_OK;
	wire           rx_any    = |RX_STORE;
	property p_no_cancel_busy; (|busy_pend) |=> ((TX_PENDING & $past(busy_pend)) == $past(busy_pend)); endproperty
	a_no_cancel_busy: assert property (p_no_cancel_busy) else $error("busy mailbox lost its request");
	property p_irq_cause; $rose(IRQ) |-> $past(rx_any) || $past(rx_any, 2) || $past(S_AXI_BVALID) || S_AXI_BVALID; endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq rose without an event");
	property p_txok_clears; (|TX_OK) |=> ~|(TX_PENDING & $past(TX_OK)); endproperty
	a_txok_clears: assert property (p_txok_clears) else $error("sent mailbox still pending");
	property p_b_hold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_r_hold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_b_blocks; S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY; endproperty
	a_b_blocks: assert property (p_b_blocks) else $error("write taken during response");
	property p_ar_block; S_AXI_RVALID |-> !S_AXI_ARREADY; endproperty
	a_ar_block: assert property (p_ar_block) else $error("read taken during response");
	property p_rd_answer; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
endmodule // csmf_flags_sva

bind csmf_flags csmf_flags_sva #(.NMB(NMB)) u_sva (.CLK_SYS(CLK_SYS), .RST(RST),
	.S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
	.S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
	.S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
	.S_AXI_RREADY(S_AXI_RREADY), .MB_ARBITRATING(MB_ARBITRATING), .MB_SENDING(MB_SENDING),
	.TX_OK(TX_OK), .RX_STORE(RX_STORE), .TX_PENDING(TX_PENDING), .IRQ(IRQ));

/* csmf_flags_tb_top.sv */
// Purpose: self-checking bench for the flag block
// Assumes: bus model serves one mailbox at a time
// Notes: handshakes are sampled at the rising edge they complete on
`timescale 1ns/1ps
module csmf_flags_tb_top;
	reg         clk = 1'b0;
	reg         rst = 1'b1;
	reg         awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
	reg  [5:0]  awa = 6'h00, ara = 6'h00;
	reg  [31:0] wd = 32'h0, rxs = 32'h0, d;
	reg  [8:0]  txe = 9'h000, rxe = 9'h000;
	reg         rxr = 1'b0, hold = 1'b0, ta, tw;
	reg  [3:0]  dlc = 4'h0;
	reg  [1:0]  r, b;
	reg  [18:0] rows [0:7];
	wire        awr, wrd, bv, arr, rv, irq, nm, idle, hq, sq;
	wire [1:0]  br, rr;
	wire [31:0] rdat, pend, arb, snd, ok;
	integer     err_total = 0, samples_checked = 0, i;

	csmf_flags dut (.CLK_SYS(clk), .RST(rst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wrd), .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
		.S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat),
		.S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .BUS_IDLE(idle),
		.INT_RESET_DONE(1'b1), .TX_ACTIVE(~idle), .TX_ERR_CNT(txe), .RX_ERR_CNT(rxe),
		.MB_ARBITRATING(arb), .MB_SENDING(snd), .TX_OK(ok), .RX_STORE(rxs), .RX_REMOTE(rxr),
		.RX_DLC(dlc), .TX_PENDING(pend), .NORMAL_MODE(nm), .HALT_REQ(hq), .SLEEP_REQ(sq), .IRQ(irq));
	csmf_can_node u_node (.clk(clk), .rst(rst), .hold(hold), .pend(pend), .arb(arb),
		.snd(snd), .ok(ok), .idle(idle));

	initial forever #5 clk = ~clk;
	initial begin
		#100000;
		err_total = err_total + 1;
		final_report;
	end

	// ----------------------------------------
	// bus and check tasks
	// ----------------------------------------
	task wr(input [5:0] a, input [31:0] v);
		begin
			@(posedge clk);
			awa <= a;
			wd  <= v;
			awv <= 1'b1;
			wv  <= 1'b1;
			bry <= 1'b1;
			tw = 1'b0;
			while (!tw) begin
				@(posedge clk);
				if (awv && awr)
					awv <= 1'b0;
				if (wv && wrd)
					wv <= 1'b0;
				if (bv) begin
					b = br;
					bry <= 1'b0;
					tw = 1'b1;
				end
			end
		end
	endtask
	task rd(input [5:0] a);
		begin
			@(posedge clk);
			ara <= a;
			arv <= 1'b1;
			rry <= 1'b1;
			ta = 1'b0;
			while (!ta) begin
				@(posedge clk);
				if (arv && arr)
					arv <= 1'b0;
				if (rv) begin
					d = rdat;
					r = rr;
					rry <= 1'b0;
					ta = 1'b1;
				end
			end
		end
	endtask
	task chk(input [31:0] g, input [31:0] e, input [8*12:1] m);
		begin
			samples_checked = samples_checked + 1;
			if (g !== e) begin
				err_total = err_total + 1;
				$display("wrong value at %0t: %0s got %h want %h", $time, m, g, e);
			end
		end
	endtask
	task rc(input [5:0] a, input [31:0] e, input [8*12:1] m);
		begin
			rd(a);
			chk(d, e, m);
		end
	endtask
	task ci(input e);
		begin
			repeat (2) @(negedge clk);
			chk({31'h0, irq}, {31'h0, e}, "irq line");
		end
	endtask
	task rx(input rm);
		begin
			@(posedge clk);
			rxs <= 32'h4;
			rxr <= rm;
			dlc <= 4'h5;
			@(posedge clk);
			rxs <= 32'h0;
		end
	endtask
	task wait_idle;
		begin
			@(negedge clk);
			while (pend !== 32'h0) @(negedge clk);
			@(posedge clk);
		end
	endtask
	task done(input [8*8:1] n);
		$display("test %0s finished", n);
	endtask
	task final_report;
		begin
			$display("checks %0d mismatches %0d", samples_checked, err_total);
			if (err_total == 0 && samples_checked > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rows[0] = {9'h05f, 9'h000, 1'b0};
		rows[1] = {9'h060, 9'h000, 1'b1};
		rows[2] = {9'h0ff, 9'h000, 1'b1};
		rows[3] = {9'h100, 9'h000, 1'b0};
		rows[4] = {9'h000, 9'h060, 1'b1};
		rows[5] = {9'h000, 9'h0ff, 1'b1};
		rows[6] = {9'h100, 9'h064, 1'b0};
		rows[7] = {9'h05f, 9'h05f, 1'b0};
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rc(6'h00, 32'hc, "status rst");
		rc(6'h0c, 32'h0, "upper rst");
		rc(6'h04, 32'h1, "ctrl rst");
		rd(6'h30);
		chk({30'h0, r}, 32'h2, "unmapped rd");
		wr(6'h30, 32'h1);
		chk({30'h0, b}, 32'h2, "unmapped wr");
		done("reset");
		for (i = 0; i < 8; i = i + 1) begin
			txe <= rows[i][18:10];
			rxe <= rows[i][9:1];
			rc(6'h00, 32'hc | {30'h0, rows[i][0], 1'b0}, "warn row");
		end
		txe <= 9'h000;
		rxe <= 9'h000;
		done("warn");
		wr(6'h2c, 32'h00020008);
		rc(6'h00, 32'h8, "tx busy");
		wait_idle;
		rc(6'h0c, 32'h2, "upper set");
		rc(6'h08, 32'h8, "lower set");
		wr(6'h0c, 32'h0);
		rc(6'h0c, 32'h2, "w0 keeps");
		wr(6'h0c, 32'h2);
		rc(6'h0c, 32'h0, "w1 clears");
		rc(6'h00, 32'hc, "tx idle");
		done("txack");
		wr(6'h1c, 32'hffffff9f);
		wr(6'h20, 32'h0000feff);
		wr(6'h2c, 32'h20);
		@(negedge clk);
		while (snd[5] !== 1'b1) @(negedge clk);
		wr(6'h28, 32'h20);
		rc(6'h2c, 32'h20, "busy kept");
		ci(1'b0);
		wait_idle;
		hold <= 1'b1;
		wr(6'h2c, 32'h40);
		wr(6'h28, 32'h40);
		rc(6'h2c, 32'h0, "cancelled");
		ci(1'b1);
		wr(6'h24, 32'h1);
		hold <= 1'b0;
		ci(1'b0);
		done("cancel");
		rx(1'b1);
		rc(6'h10, 32'h4, "remote set");
		ci(1'b0);
		rc(6'h28, 32'h5, "length");
		wr(6'h10, 32'h4);
		wr(6'h1c, 32'hffffff9b);
		wr(6'h20, 32'h0000fcfb);
		rx(1'b1);
		ci(1'b1);
		wr(6'h24, 32'h7);
		wr(6'h18, 32'hffffffff);
		wr(6'h14, 32'hffffffff);
		rx(1'b0);
		rx(1'b0);
		rc(6'h14, 32'h4, "overwrite");
		ci(1'b1);
		done("rx");
		wr(6'h04, 32'h0);
		@(negedge clk);
		while (nm !== 1'b1) @(negedge clk);
		rc(6'h00, 32'h4, "normal");
		wr(6'h04, 32'h2);
		rc(6'h00, 32'h14, "halt");
		chk({30'h0, sq, hq}, 32'h1, "halt pin");
		wr(6'h04, 32'h20);
		rc(6'h00, 32'h14, "sleep");
		chk({30'h0, sq, hq}, 32'h2, "sleep pin");
		wr(6'h04, 32'h1);
		rc(6'h00, 32'hc, "config");
		wr(6'h04, 32'h2);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rc(6'h04, 32'h1, "ctrl rst2");
		rc(6'h00, 32'hc, "status rst2");
		done("mode");
		final_report;
	end
endmodule // csmf_flags_tb_top
